// ### hdl/anrb_cfg.svh
// register numbers, reset values and identity of the bank
`ifndef ANRB_CFG_SVH
`define ANRB_CFG_SVH
`define ANRB_REG_ID_HIGH   5'h02
`define ANRB_REG_ID_LOW    5'h03
`define ANRB_REG_ADV       5'h04
`define ANRB_REG_PARTNER   5'h05
`define ANRB_REG_EXPANSION 5'h06
`define ANRB_REG_NP_TX     5'h07
`define ANRB_REG_NP_RX     5'h08
// organization identifier: value is arbitrary, not a real assignment
`define ANRB_ORG_ID_HIGH   16'h0123
`define ANRB_ORG_ID_LOW6   6'h2a
`define ANRB_ADV_FAULT_RST 2'h0
`define ANRB_ADV_PAUSE_RST 2'h3
`define ANRB_ADV_FDX_RST   1'h1
// advertisement image after any restore: pause both, full duplex
`define ANRB_ADV_WORD_RST  16'h01a0
`define ANRB_NP_NULL_CODE  11'h001
`define ANRB_ZERO16        16'h0000
`endif

// ### hdl/anrb_pkg.sv
// types shared by the auto-negotiation register bank
package anrb_pkg;
  // advertisement fields that software or the config port can load
  typedef struct packed {
    logic [1:0] fault;
    logic [1:0] pause;
    logic       full_duplex;
  } anrb_adv_s;

  // base or next page as delivered by the negotiation engine
  typedef struct packed {
    logic        next_page;
    logic        ack;
    logic        message;
    logic        ack2;
    logic        toggle;
    logic [10:0] code;
  } anrb_page_s;

  // transmit next-page storage
  typedef struct packed {
    logic        more;
    logic        message;
    logic        ack2;
    logic        toggle;
    logic [10:0] code;
  } anrb_nptx_s;

  // complete state of the bank
  typedef struct packed {
    anrb_adv_s   adv;
    logic [15:0] partner;
    logic        page_rx;
    anrb_nptx_s  np_tx;
    logic [15:0] np_rx;
    logic [15:0] rd_data;
    logic [15:0] adv_out;
  } anrb_state_s;
endpackage

// ### hdl/anrb_bank.sv
// management register bank for clause-37 auto-negotiation, registers 2..8
// Operation
// R1 - read-only identifier, model and revision zero
// R2 - advertisement loaded by writes or config port
// R3 - next-page advertisement bit ignored, reads zero
// R4 - fault field writable, clears when negotiation completes
// R5 - pause field writable, resets to both
// R6 - half-duplex advertisement bit always reads zero
// R7 - full-duplex bit programmable, resets one, fdx kept
// R8 - reserved advertisement bits read zero, writes dropped
// R9 - partner base page read-only, resets zero
// R10 - partner acknowledge bit reflects received page
// R11 - page-received flag set on page, read clears
// R12 - next-page-able expansion bit reads one
// R13 - next-page transmit layout, code defaults null
// R14 - transmit toggle bit alternates between next pages
// R15 - next-page transmit register always reads zero
// R16 - received next page read-only, resets zero
// R17 - unassigned addresses read zero, writes ignored
// R18 - hardware, lock-loss and soft reset restore defaults
// R19 - reads return current sixteen-bit register value
`include "anrb_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module anrb_bank
(
  input  wire logic               clock,
  input  wire logic               rst,
  input  wire logic               clock_locked,
  input  wire logic               soft_reset,
  input  wire logic               mgmt_rd,
  input  wire logic               mgmt_wr,
  input  wire logic [4:0]         mgmt_addr,
  input  wire logic [15:0]        mgmt_wdata,
  input  wire logic               cfg_valid,
  input  wire anrb_pkg::anrb_adv_s cfg_adv,
  input  wire logic               an_complete,
  input  wire logic               base_valid,
  input  wire anrb_pkg::anrb_page_s base_page,
  input  wire logic               next_valid,
  input  wire anrb_pkg::anrb_page_s next_page,
  input  wire logic               np_tx_sent,
  output logic [15:0]             mgmt_rdata,
  output logic [15:0]             adv_word,
  output logic                    page_received,
  output logic                    duplex_full
);
  anrb_pkg::anrb_state_s state;
  anrb_pkg::anrb_state_s next_state;
  logic                  wipe;
  logic [15:0]           adv_view;
  logic [15:0]           exp_view;

  // lock loss and soft reset act as a synchronous restore
  assign wipe = soft_reset || !clock_locked; // [R18]

  // advertisement word as seen on the bus and by the engine
  always_comb
  begin
    adv_view = `ANRB_ZERO16; // [R3] [R6] [R8]
    adv_view[13:12] = state.adv.fault;
    adv_view[8:7] = state.adv.pause;
    adv_view[5] = state.adv.full_duplex;
    exp_view = `ANRB_ZERO16;
    exp_view[2] = 1'b1; // [R12]
    exp_view[1] = state.page_rx;
  end

  // next-state logic for the whole bank
  always_comb
  begin
    next_state = state;
    // management writes land before the config port, so the port wins
    if (mgmt_wr && mgmt_addr == `ANRB_REG_ADV)
    begin
      next_state.adv.fault = mgmt_wdata[13:12]; // [R4]
      next_state.adv.pause = mgmt_wdata[8:7]; // [R5]
      next_state.adv.full_duplex = mgmt_wdata[5]; // [R7]
    end
    if (cfg_valid)
      next_state.adv = cfg_adv; // [R2]
    // completion clears the fault field after any write this cycle
    if (an_complete)
      next_state.adv.fault = `ANRB_ADV_FAULT_RST; // [R4]
    // transmit page is stored though never returned on reads
    if (mgmt_wr && mgmt_addr == `ANRB_REG_NP_TX)
    begin
      next_state.np_tx.more = mgmt_wdata[15]; // [R13]
      next_state.np_tx.message = mgmt_wdata[13];
      next_state.np_tx.ack2 = mgmt_wdata[12];
      next_state.np_tx.code = mgmt_wdata[10:0];
    end
    if (np_tx_sent)
      next_state.np_tx.toggle = !state.np_tx.toggle; // [R14]
    if (base_valid)
    begin
      next_state.partner = `ANRB_ZERO16; // [R9]
      next_state.partner[15] = base_page.next_page;
      next_state.partner[14] = base_page.ack; // [R10]
      next_state.partner[13:12] = base_page.code[10:9];
      next_state.partner[8:7] = base_page.code[4:3];
      next_state.partner[6] = base_page.code[2];
      next_state.partner[5] = base_page.code[1];
    end
    if (next_valid)
      next_state.np_rx = next_page; // [R16]
    // read clears, but a page in the same cycle keeps the flag set
    if (mgmt_rd && mgmt_addr == `ANRB_REG_EXPANSION)
      next_state.page_rx = 1'b0;
    if (base_valid || next_valid)
      next_state.page_rx = 1'b1; // [R11]
    // read mux; unmapped and transmit-page addresses read zero
    next_state.rd_data = `ANRB_ZERO16; // [R17] [R19]
    case (mgmt_addr)
      `ANRB_REG_ID_HIGH:
        next_state.rd_data = `ANRB_ORG_ID_HIGH; // [R1]
      `ANRB_REG_ID_LOW:
        next_state.rd_data = {`ANRB_ORG_ID_LOW6, 10'h000}; // [R1]
      `ANRB_REG_ADV:
        next_state.rd_data = adv_view;
      `ANRB_REG_PARTNER:
        next_state.rd_data = state.partner;
      `ANRB_REG_EXPANSION:
        next_state.rd_data = exp_view;
      `ANRB_REG_NP_TX:
        next_state.rd_data = `ANRB_ZERO16; // [R15]
      `ANRB_REG_NP_RX:
        next_state.rd_data = state.np_rx;
      default:
        next_state.rd_data = `ANRB_ZERO16;
    endcase
    // engine image follows the newly loaded fields at the same edge, so
    // the engine never advertises a value one cycle stale
    next_state.adv_out = `ANRB_ZERO16; // [R8]
    next_state.adv_out[13:12] = next_state.adv.fault;
    next_state.adv_out[8:7] = next_state.adv.pause;
    next_state.adv_out[5] = next_state.adv.full_duplex;
  end

  // state register with async hardware reset and sync restores
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state <= '0; // [R18]
      state.adv.pause <= `ANRB_ADV_PAUSE_RST;
      state.adv.full_duplex <= `ANRB_ADV_FDX_RST;
      state.adv_out <= `ANRB_ADV_WORD_RST;
      state.np_tx.message <= 1'b1;
      state.np_tx.code <= `ANRB_NP_NULL_CODE;
    end
    else if (wipe)
    begin
      state <= '0; // [R18]
      state.adv.pause <= `ANRB_ADV_PAUSE_RST;
      state.adv.full_duplex <= `ANRB_ADV_FDX_RST;
      state.adv_out <= `ANRB_ADV_WORD_RST;
      state.np_tx.message <= 1'b1;
      state.np_tx.code <= `ANRB_NP_NULL_CODE;
    end
    else
      state <= next_state;
  end

  // duplex stays full whatever is advertised
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      duplex_full <= 1'b1; // [R7]
    else
      duplex_full <= 1'b1;
  end

  assign mgmt_rdata = state.rd_data;
  assign adv_word = state.adv_out;
  assign page_received = state.page_rx;

  // checks beside the logic
  AST_ADV_RESERVED_ZERO: assert property (@(posedge clock) disable iff (rst)
    (adv_word[15:14] == 2'h0) && (adv_word[11:9] == 3'h0)
    && (adv_word[6:0] & 7'h5f) == 7'h00) // [R8]
    else $error("reserved advertisement bits not zero");
  AST_NP_BIT_IGNORED: assert property (@(posedge clock) disable iff (rst)
    mgmt_wr && mgmt_addr == `ANRB_REG_ADV && mgmt_wdata[15] && !wipe
    |=> !adv_word[15]) // [R3]
    else $error("next-page advertisement bit set");
  AST_FAULT_CLEAR: assert property (@(posedge clock) disable iff (rst)
    an_complete |=> adv_word[13:12] == 2'h0) // [R4]
    else $error("fault not cleared at completion");
  AST_PAGE_FLAG: assert property (@(posedge clock) disable iff (rst)
    (base_valid || next_valid) && !wipe |=> page_received) // [R11]
    else $error("page flag not set");
  AST_PAGE_READ_CLEAR: assert property (@(posedge clock) disable iff (rst)
    mgmt_rd && mgmt_addr == `ANRB_REG_EXPANSION && !base_valid
    && !next_valid |=> !page_received) // [R11]
    else $error("page flag not cleared by read");
  AST_NPTX_ZERO: assert property (@(posedge clock) disable iff (rst)
    mgmt_addr == `ANRB_REG_NP_TX |=> mgmt_rdata == 16'h0000) // [R15]
    else $error("transmit page read not zero");
  AST_UNMAPPED_ZERO: assert property (@(posedge clock) disable iff (rst)
    mgmt_addr > `ANRB_REG_NP_RX || mgmt_addr < `ANRB_REG_ID_HIGH
    |=> mgmt_rdata == 16'h0000) // [R17]
    else $error("unmapped read not zero");
  AST_EXP_ABLE: assert property (@(posedge clock) disable iff (rst)
    mgmt_addr == `ANRB_REG_EXPANSION && !wipe |=> mgmt_rdata[2]
    && mgmt_rdata[15:3] == 13'h0000) // [R12]
    else $error("expansion layout wrong");
  AST_ID_LOW: assert property (@(posedge clock) disable iff (rst)
    mgmt_addr == `ANRB_REG_ID_LOW |=> mgmt_rdata[9:0] == 10'h000) // [R1]
    else $error("model or revision not zero");
  AST_WIPE_DEFAULT: assert property (@(posedge clock) disable iff (rst)
    wipe |=> adv_word == 16'h01a0 && !page_received) // [R18]
    else $error("restore did not load defaults");
  AST_FDX_KEPT: assert property (@(posedge clock) disable iff (rst)
    duplex_full) // [R7]
    else $error("duplex not full");

  // read path: each address returns the register as it stood at the edge
  AST_ID_HIGH: assert property (@(posedge clock) disable iff (rst) // [R1]
    mgmt_addr == `ANRB_REG_ID_HIGH && !wipe
    |=> mgmt_rdata == `ANRB_ORG_ID_HIGH)
    else $error("identifier high word wrong");
  AST_ID_LOW_ORG: assert property (@(posedge clock) disable iff (rst) // [R1]
    mgmt_addr == `ANRB_REG_ID_LOW && !wipe
    |=> mgmt_rdata[15:10] == `ANRB_ORG_ID_LOW6)
    else $error("identifier low bits wrong");
  AST_ADV_READ: assert property (@(posedge clock) disable iff (rst) // [R19]
    mgmt_addr == `ANRB_REG_ADV && !wipe
    |=> mgmt_rdata == $past(adv_word))
    else $error("advertisement read differs from image");
  AST_ADV_RSVD_READ: assert property (@(posedge clock) disable iff (rst) // [R8]
    mgmt_addr == `ANRB_REG_ADV && !wipe
    |=> mgmt_rdata[15:14] == 2'h0 && mgmt_rdata[11:9] == 3'h0
    && mgmt_rdata[6] == 1'b0 && mgmt_rdata[4:0] == 5'h00)
    else $error("advertisement read shows reserved bits");
  AST_PARTNER_READ: assert property (@(posedge clock) disable iff (rst) // [R9]
    mgmt_addr == `ANRB_REG_PARTNER && !wipe
    |=> mgmt_rdata == $past(state.partner))
    else $error("partner read differs from store");
  AST_NPRX_READ: assert property (@(posedge clock) disable iff (rst) // [R16]
    mgmt_addr == `ANRB_REG_NP_RX && !wipe
    |=> mgmt_rdata == $past(state.np_rx))
    else $error("next page read differs from store");
  AST_EXP_FLAG_READ: assert property (@(posedge clock) disable iff (rst) // [R11]
    mgmt_addr == `ANRB_REG_EXPANSION && !wipe
    |=> mgmt_rdata[1] == $past(page_received))
    else $error("expansion read lost the page flag");
  AST_WIPE_RDATA: assert property (@(posedge clock) disable iff (rst) // [R18]
    wipe |=> mgmt_rdata == 16'h0000)
    else $error("read data not cleared by restore");

  // advertisement loading: write, config port, and hold otherwise
  AST_ADV_WRITE: assert property (@(posedge clock) disable iff (rst) // [R5]
    mgmt_wr && mgmt_addr == `ANRB_REG_ADV && !cfg_valid && !an_complete
    && !wipe
    |=> adv_word[13:12] == $past(mgmt_wdata[13:12])
    && adv_word[8:7] == $past(mgmt_wdata[8:7])
    && adv_word[5] == $past(mgmt_wdata[5]))
    else $error("advertisement write did not land");
  AST_CFG_LOAD: assert property (@(posedge clock) disable iff (rst) // [R2]
    cfg_valid && !an_complete && !wipe
    |=> adv_word[13:12] == $past(cfg_adv.fault)
    && adv_word[8:7] == $past(cfg_adv.pause)
    && adv_word[5] == $past(cfg_adv.full_duplex))
    else $error("config port load did not land");
  AST_ADV_HOLD: assert property (@(posedge clock) disable iff (rst) // [R2]
    !(mgmt_wr && mgmt_addr == `ANRB_REG_ADV) && !cfg_valid
    && !an_complete && !wipe
    |=> $stable(adv_word))
    else $error("advertisement changed with no load");
  AST_HALF_ZERO: assert property (@(posedge clock) disable iff (rst) // [R6]
    adv_word[6] == 1'b0)
    else $error("half duplex advertised");

  // received pages: capture on the strobe, hold between strobes
  AST_BASE_ACK: assert property (@(posedge clock) disable iff (rst) // [R10]
    base_valid && !wipe
    |=> state.partner[15] == $past(base_page.next_page)
    && state.partner[14] == $past(base_page.ack))
    else $error("partner acknowledge not captured");
  AST_BASE_FIELDS: assert property (@(posedge clock) disable iff (rst) // [R9]
    base_valid && !wipe
    |=> state.partner[13:12] == $past(base_page.code[10:9])
    && state.partner[8:7] == $past(base_page.code[4:3]))
    else $error("partner fields not captured");
  AST_PARTNER_RSVD: assert property (@(posedge clock) disable iff (rst) // [R9]
    state.partner[11:9] == 3'h0 && state.partner[4:0] == 5'h00)
    else $error("partner reserved bits set");
  AST_PARTNER_HOLD: assert property (@(posedge clock) disable iff (rst) // [R9]
    !base_valid && !wipe |=> $stable(state.partner))
    else $error("partner page changed with no strobe");
  AST_NPRX_CAPTURE: assert property (@(posedge clock) disable iff (rst) // [R16]
    next_valid && !wipe |=> state.np_rx == $past(next_page))
    else $error("next page not captured");
  AST_NPRX_HOLD: assert property (@(posedge clock) disable iff (rst) // [R16]
    !next_valid && !wipe |=> $stable(state.np_rx))
    else $error("next page changed with no strobe");
  AST_FLAG_HOLD: assert property (@(posedge clock) disable iff (rst) // [R11]
    !base_valid && !next_valid && !wipe
    && !(mgmt_rd && mgmt_addr == `ANRB_REG_EXPANSION)
    |=> $stable(page_received))
    else $error("page flag changed with no cause");

  // transmit page store: hidden from reads but still kept
  AST_TOGGLE: assert property (@(posedge clock) disable iff (rst) // [R14]
    np_tx_sent && !wipe
    |=> state.np_tx.toggle != $past(state.np_tx.toggle))
    else $error("transmit toggle did not alternate");
  AST_NPTX_WRITE: assert property (@(posedge clock) disable iff (rst) // [R13]
    mgmt_wr && mgmt_addr == `ANRB_REG_NP_TX && !wipe
    |=> state.np_tx.code == $past(mgmt_wdata[10:0]))
    else $error("transmit code not stored");
  AST_WIPE_REGS: assert property (@(posedge clock) disable iff (rst) // [R18]
    wipe |=> state.partner == 16'h0000 && state.np_rx == 16'h0000
    && state.np_tx.code == `ANRB_NP_NULL_CODE && state.np_tx.message)
    else $error("restore left page stores dirty");

  COV_ADV_WRITE: cover property (@(posedge clock) disable iff (rst)
    mgmt_wr && mgmt_addr == `ANRB_REG_ADV ##1 mgmt_rd);
  COV_PAGE_THEN_READ: cover property (@(posedge clock) disable iff (rst)
    base_valid ##[1:4] mgmt_rd && mgmt_addr == `ANRB_REG_EXPANSION);
  COV_CFG_LOAD: cover property (@(posedge clock) disable iff (rst)
    cfg_valid ##1 an_complete);
  COV_SOFT_RESTORE: cover property (@(posedge clock) disable iff (rst)
    soft_reset ##1 mgmt_rd);
  COV_NEXT_PAGE: cover property (@(posedge clock) disable iff (rst)
    next_valid ##[1:4] mgmt_rd && mgmt_addr == `ANRB_REG_NP_RX);
endmodule
`default_nettype wire

// ### bench/anrb_page_src.sv
// stand-in for the negotiation engine: hands received pages to the bank
`timescale 1ns/1ps
`default_nettype none
module anrb_page_src
(
  input  wire logic                clock,
  output var  logic                base_valid,
  output var  anrb_pkg::anrb_page_s base_page,
  output var  logic                next_valid,
  output var  anrb_pkg::anrb_page_s next_page
);
  initial
  begin
    base_valid = 1'b0;
    next_valid = 1'b0;
    base_page = 16'h0000;
    next_page = 16'h0000;
  end

  // a page stands for one edge; afterwards the bus shows the inverse, so a
  // bank that samples late cannot pass by reading stale data
  task automatic send(input logic is_next, input anrb_pkg::anrb_page_s p);
    @(negedge clock);
    base_valid = !is_next;
    next_valid = is_next;
    base_page = p;
    next_page = p;
    @(negedge clock);
    base_valid = 1'b0;
    next_valid = 1'b0;
    base_page = ~p;
    next_page = ~p;
  endtask
endmodule
`default_nettype wire

// ### bench/tb.sv
// self-checking bench for the auto-negotiation register bank
`include "anrb_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic                 clock = 1'b0;
  logic                 rst = 1'b1;
  logic                 clock_locked = 1'b1;
  logic                 soft_reset = 1'b0;
  logic                 mgmt_rd = 1'b0;
  logic                 mgmt_wr = 1'b0;
  logic [4:0]           mgmt_addr = 5'h00;
  logic [15:0]          mgmt_wdata = 16'h0000;
  logic                 cfg_valid = 1'b0;
  anrb_pkg::anrb_adv_s  cfg_adv = 5'h00;
  logic                 an_complete = 1'b0;
  logic                 np_tx_sent = 1'b0;
  logic                 base_valid;
  logic                 next_valid;
  anrb_pkg::anrb_page_s base_page;
  anrb_pkg::anrb_page_s next_page;
  logic [15:0]          mgmt_rdata;
  logic [15:0]          adv_word;
  logic                 page_received;
  logic                 duplex_full;
  int                   n_errors = 0;
  int                   check_count = 0;

  anrb_bank dut (.clock(clock), .rst(rst), .clock_locked(clock_locked),
    .soft_reset(soft_reset), .mgmt_rd(mgmt_rd), .mgmt_wr(mgmt_wr),
    .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .cfg_valid(cfg_valid),
    .cfg_adv(cfg_adv), .an_complete(an_complete), .base_valid(base_valid),
    .base_page(base_page), .next_valid(next_valid), .next_page(next_page),
    .np_tx_sent(np_tx_sent), .mgmt_rdata(mgmt_rdata), .adv_word(adv_word),
    .page_received(page_received), .duplex_full(duplex_full));
  anrb_page_src src (.clock(clock), .base_valid(base_valid),
    .base_page(base_page), .next_valid(next_valid), .next_page(next_page));

  // 25 ns period
  initial
  begin
    forever #12.5 clock = ~clock;
  end

  task automatic chk(input string what, input logic [15:0] exp,
                     input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  // address held through the sampling edge; answer looked at half a cycle on
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(negedge clock);
    mgmt_addr = a;
    mgmt_rd = 1'b1;
    @(negedge clock);
    mgmt_rd = 1'b0;
    chk("mgmt_rdata", exp, mgmt_rdata);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clock);
    mgmt_addr = a;
    mgmt_wdata = d;
    mgmt_wr = 1'b1;
    @(negedge clock);
    mgmt_wr = 1'b0;
  endtask

  task automatic pulse(ref logic s);
    @(negedge clock);
    s = 1'b1;
    @(negedge clock);
    s = 1'b0;
  endtask

  // defaults of addresses 0 to 9, unassigned ones 0, 1 and 9 included
  task automatic t_defaults;
    logic [15:0] tab [0:9];
    tab = '{16'h0000, 16'h0000, `ANRB_ORG_ID_HIGH,
            {`ANRB_ORG_ID_LOW6, 10'h000}, 16'h01a0, 16'h0000, 16'h0004,
            16'h0000, 16'h0000, 16'h0000};
    for (int i = 0; i < 10; i++)
      rd(i[4:0], tab[i]);
    chk("adv_word", 16'h01a0, adv_word);
  endtask

  // writes: reserved and fixed bits dropped, read-only places kept
  task automatic t_writes;
    wr(5'h04, 16'hffff);
    rd(5'h04, 16'h31a0);
    wr(5'h04, 16'h0000);
    rd(5'h04, 16'h0000);
    chk("duplex_full", 16'h0001, {15'h0000, duplex_full});
    wr(5'h02, 16'hffff);
    rd(5'h02, `ANRB_ORG_ID_HIGH);
    wr(5'h07, 16'hffff);
    pulse(np_tx_sent);
    rd(5'h07, 16'h0000);
    wr(5'h09, 16'hffff);
    rd(5'h09, 16'h0000);
  endtask

  // config port load, then completion wipes the fault field
  task automatic t_config;
    cfg_adv = '{fault: 2'h2, pause: 2'h1, full_duplex: 1'b1};
    pulse(cfg_valid);
    rd(5'h04, 16'h20a0);
    pulse(an_complete);
    rd(5'h04, 16'h00a0);
  endtask

  // base page, read-clear of the flag, raw next page
  task automatic t_pages;
    src.send(1'b0, 16'hc61e);
    chk("page_received", 16'h0001, {15'h0000, page_received});
    rd(5'h05, 16'hf1e0);
    rd(5'h06, 16'h0006);
    rd(5'h06, 16'h0004);
    src.send(1'b1, 16'h2abc);
    rd(5'h08, 16'h2abc);
  endtask

  // soft reset, lock loss and a mid-run hardware reset restore defaults
  task automatic t_restore;
    wr(5'h04, 16'h0000);
    pulse(soft_reset);
    chk("adv_word", 16'h01a0, adv_word);
    wr(5'h04, 16'h0000);
    @(negedge clock);
    clock_locked = 1'b0;
    @(negedge clock);
    clock_locked = 1'b1;
    chk("adv_word", 16'h01a0, adv_word);
    src.send(1'b0, 16'hc61e);
    pulse(rst);
    rd(5'h05, 16'h0000);
  endtask

  task automatic end_sim;
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // bounded run: a hang counts as a mismatch
  initial
  begin
    #100000;
    n_errors++;
    end_sim();
  end

  initial
  begin
    repeat (3) @(negedge clock);
    rst = 1'b0;
    t_defaults();
    t_writes();
    t_config();
    t_pages();
    t_restore();
    end_sim();
  end
endmodule
`default_nettype wire
